// *** hw/maint_command.sv ***
// Maintenance command interpreter with calibration, storage, seal and pass-through control.
`timescale 1ns/1ps
`include "gauge_regs.svh"
module maint_command
  import gauge_pkg::*;
#(
  parameter int TICK_CYCLES = `GG_TICK_CYCLES,
  parameter logic [15:0] REVISION = 16'h0001 // Arbitrary value.
) (
  input wire logic clk,
  input wire logic nrst,
  input wire cmd_bus_t cmd_bus,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic host_addr_valid,
  input wire logic [7:0] host_addr_byte,
  input wire logic ee_load,
  input wire logic [15:0] ee_cap_threshold,
  input wire logic [15:0] ee_time_threshold,
  input wire logic cal_offset_found,
  input wire logic cal_saved,
  input wire logic [15:0] full_charge_capacity_value,
  input wire logic [7:0] sync_percent,
  input wire logic [15:0] charge_left,
  input wire logic [15:0] mean_time_left,
  input wire logic [15:0] battery_mode_word,
  output cal_ctrl_t cal_ctrl,
  output ee_ctrl_t ee_ctrl,
  output logic led_blank,
  output logic sealed,
  output logic offset_correction_valid,
  output logic storage_mode,
  output logic charge_sync_load,
  output logic [15:0] charge_left_internal,
  output logic alarm_capacity,
  output logic alarm_time,
  output logic capacity_units_10mw
);
  localparam int TW = `GG_TIMER_W;
  localparam int DW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

  generate
    if (TICK_CYCLES < 1) begin : g_chk
      $error("TICK_CYCLES must be at least one");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  logic rst_meta;
  logic rst_n;

  // Reset is released through two flops so every flop leaves reset on one edge.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [DW-1:0] div;
  logic [DW-1:0] next_div;
  logic tick;
  logic next_tick;
  logic [9:0] boot_ms;
  logic [9:0] next_boot_ms;
  logic cmd_ready;
  logic next_cmd_ready;

  always_comb begin
    next_div = div + 1'b1;
    next_tick = 1'b0;
    if (div >= DW'(TICK_CYCLES - 1)) begin
      next_div = '0;
      next_tick = 1'b1;
    end
    next_boot_ms = boot_ms;
    next_cmd_ready = cmd_ready;
    if (tick && !cmd_ready) begin
      next_boot_ms = boot_ms + 10'h001;
      if (boot_ms >= 10'(`GG_RESET_IGNORE_MS - 1)) begin
        next_cmd_ready = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div <= '0;
      tick <= 1'b0;
      boot_ms <= 10'h000;
      cmd_ready <= 1'b0;
    end else begin
      div <= next_div;
      tick <= next_tick;
      boot_ms <= next_boot_ms;
      cmd_ready <= next_cmd_ready;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic cal_permits(input logic [15:0] code);
    cal_permits = (code == `GG_CODE_STORAGE) || (code == `GG_CODE_CAL_STOP) ||
                  (code == `GG_CODE_SEAL);
  endfunction

  cal_state_t cal_state;
  cal_state_t next_cal_state;
  storage_state_t st_state;
  storage_state_t next_st_state;
  logic in_cal;
  logic go;
  logic c_storage;
  logic c_seal;
  logic c_sync;
  logic c_cal;
  logic c_stop;
  logic c_prog;
  logic c_rev;
  logic cal_done;

  always_comb begin
    in_cal = (cal_state != CAL_IDLE);
    go = cmd_bus.wr && (cmd_bus.code == `GG_CMD_MAINT) && cmd_ready && !ee_ctrl.route;
    go = go && (!in_cal || cal_permits(cmd_bus.wdata));
    c_storage = go && (cmd_bus.wdata == `GG_CODE_STORAGE);
    c_seal = go && (cmd_bus.wdata == `GG_CODE_SEAL);
    c_sync = go && (cmd_bus.wdata == `GG_CODE_SYNC);
    c_cal = go && !sealed && !in_cal && ((cmd_bus.wdata == `GG_CODE_CAL) ||
            (cmd_bus.wdata == `GG_CODE_CAL_ALT));
    c_stop = go && (cmd_bus.wdata == `GG_CODE_CAL_STOP);
    c_prog = go && !sealed && (cmd_bus.wdata == `GG_CODE_PROGRAM);
    c_rev = go && (cmd_bus.wdata == `GG_CODE_REVISION);
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] maint_command;
  logic [15:0] next_maint_command;
  logic clear_pend;
  logic next_clear_pend;
  logic [15:0] low_capacity_threshold;
  logic [15:0] next_low_cap;
  logic [15:0] low_time_threshold;
  logic [15:0] next_low_time;
  logic ee_loaded;
  logic next_ee_loaded;
  logic [15:0] next_rdata;
  logic next_rvalid;

  always_comb begin
    next_maint_command = maint_command;
    if (clear_pend) begin
      next_maint_command = `GG_CMD_RESET;
    end
    // A write in the clearing cycle wins over the clear.
    if (cmd_bus.wr && cmd_bus.code == `GG_CMD_MAINT) begin
      next_maint_command = cmd_bus.wdata;
    end
    if (c_rev) begin
      next_maint_command = REVISION;
    end
    next_clear_pend = c_storage || c_seal || c_sync || c_cal || c_stop || c_prog;
    next_low_cap = low_capacity_threshold;
    next_low_time = low_time_threshold;
    next_ee_loaded = ee_loaded;
    if (ee_load && !ee_loaded) begin
      next_low_cap = ee_cap_threshold;
      next_low_time = ee_time_threshold;
      next_ee_loaded = 1'b1;
    end
    if (cmd_bus.wr && cmd_bus.code == `GG_CMD_LOW_CAP) begin
      next_low_cap = cmd_bus.wdata;
    end
    if (cmd_bus.wr && cmd_bus.code == `GG_CMD_LOW_TIME) begin
      next_low_time = cmd_bus.wdata;
    end
    next_rvalid = cmd_bus.rd;
    next_rdata = reg_rdata;
    if (cmd_bus.rd) begin
      case (cmd_bus.code)
        `GG_CMD_MAINT: next_rdata = maint_command;
        `GG_CMD_LOW_CAP: next_rdata = low_capacity_threshold;
        `GG_CMD_LOW_TIME: next_rdata = low_time_threshold;
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      maint_command <= `GG_CMD_RESET;
      clear_pend <= 1'b0;
      low_capacity_threshold <= `GG_THRESH_RESET;
      low_time_threshold <= `GG_THRESH_RESET;
      ee_loaded <= 1'b0;
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      maint_command <= next_maint_command;
      clear_pend <= next_clear_pend;
      low_capacity_threshold <= next_low_cap;
      low_time_threshold <= next_low_time;
      ee_loaded <= next_ee_loaded;
      reg_rdata <= next_rdata;
      reg_rvalid <= next_rvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic cal_load;
  logic [TW-1:0] cal_load_val;
  logic cal_expired;
  cal_ctrl_t next_cal_ctrl;
  logic next_ocv;
  logic next_led_blank;
  logic next_sealed;
  ee_ctrl_t next_ee_ctrl;
  logic next_sync_load;
  logic [15:0] next_charge_int;
  logic [23:0] sync_product;

  tick_timer #(.W(TW)) cal_timer (
    .clk(clk), .rst_n(rst_n), .tick(tick), .load(cal_load), .load_val(cal_load_val),
    .stop(c_stop), .running(), .expired(cal_expired)
  );

  always_comb begin
    next_cal_state = cal_state;
    next_cal_ctrl = cal_ctrl;
    next_ocv = offset_correction_valid;
    cal_load = 1'b0;
    cal_load_val = TW'(`GG_CAL_START_MS);
    cal_done = 1'b0;
    case (cal_state)
      CAL_IDLE: begin
        if (c_cal) begin
          next_cal_state = CAL_WAIT;
          cal_load = 1'b1;
          next_cal_ctrl.sense_disconnect = (cmd_bus.wdata == `GG_CODE_CAL);
        end
      end
      CAL_WAIT: begin
        if (cal_expired) begin
          next_cal_state = CAL_RUN;
          cal_load = 1'b1;
          cal_load_val = TW'(`GG_CAL_CAP_MS);
          next_cal_ctrl.active = 1'b1;
          next_ocv = 1'b0;
        end
      end
      CAL_RUN: begin
        if (cal_offset_found) begin
          next_cal_state = CAL_SAVE;
          next_cal_ctrl.save_req = 1'b1;
        end else if (cal_expired) begin
          next_cal_state = CAL_IDLE;
          next_cal_ctrl.active = 1'b0;
          cal_done = 1'b1;
        end
      end
      CAL_SAVE: begin
        if (cal_saved) begin
          next_cal_state = CAL_IDLE;
          next_cal_ctrl = '{default: 1'b0};
          next_cal_ctrl.correction_on = 1'b1;
          next_ocv = 1'b1;
          cal_done = 1'b1;
        end
      end
      default: next_cal_state = CAL_IDLE;
    endcase
    if (c_stop) begin
      next_cal_state = CAL_IDLE;
      next_cal_ctrl = '{default: 1'b0};
    end
    next_led_blank = (next_cal_state == CAL_RUN) || (next_cal_state == CAL_SAVE);
    next_sealed = sealed || c_seal;
    next_ee_ctrl = ee_ctrl;
    if (c_prog) begin
      next_ee_ctrl = '{route: 1'b1, power: 1'b1, suspend: 1'b1};
    end else if (ee_ctrl.route && host_addr_valid && host_addr_byte == `GG_BATT_ADDR_WR) begin
      next_ee_ctrl = '{default: 1'b0};
    end
    sync_product = 24'(full_charge_capacity_value * sync_percent);
    next_sync_load = c_sync;
    next_charge_int = charge_left_internal;
    if (c_sync) begin
      next_charge_int = 16'(sync_product / `GG_PCT_DIVISOR);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_state <= CAL_IDLE;
      cal_ctrl <= '{default: 1'b0};
      offset_correction_valid <= 1'b0;
      led_blank <= 1'b0;
      sealed <= 1'b0;
      ee_ctrl <= '{default: 1'b0};
      charge_sync_load <= 1'b0;
      charge_left_internal <= 16'h0000;
    end else begin
      cal_state <= next_cal_state;
      cal_ctrl <= next_cal_ctrl;
      offset_correction_valid <= next_ocv;
      led_blank <= next_led_blank;
      sealed <= next_sealed;
      ee_ctrl <= next_ee_ctrl;
      charge_sync_load <= next_sync_load;
      charge_left_internal <= next_charge_int;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic st_load;
  logic [TW-1:0] st_load_val;
  logic st_expired;
  logic next_storage_mode;

  tick_timer #(.W(TW)) storage_timer (
    .clk(clk), .rst_n(rst_n), .tick(tick), .load(st_load), .load_val(st_load_val),
    .stop(1'b0), .running(), .expired(st_expired)
  );

  always_comb begin
    next_st_state = st_state;
    st_load = 1'b0;
    st_load_val = TW'(`GG_STORAGE_DELAY_MS);
    case (st_state)
      ST_IDLE: begin
        if (c_storage) begin
          next_st_state = ST_DELAY;
          st_load = 1'b1;
        end
      end
      ST_DELAY: begin
        if (cal_done) begin
          next_st_state = ST_FINAL;
          st_load = 1'b1;
          st_load_val = TW'(`GG_POST_CAL_MS);
        end else if (st_expired) begin
          next_st_state = (in_cal || c_cal) ? ST_DEFER : ST_ENTERED;
        end
      end
      ST_DEFER: begin
        if (cal_done || !in_cal) begin
          next_st_state = ST_FINAL;
          st_load = 1'b1;
          st_load_val = TW'(`GG_POST_CAL_MS);
        end
      end
      ST_FINAL: begin
        if (st_expired) begin
          next_st_state = ST_ENTERED;
        end
      end
      ST_ENTERED: next_st_state = ST_ENTERED;
      default: next_st_state = ST_IDLE;
    endcase
    next_storage_mode = (next_st_state == ST_ENTERED);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_state <= ST_IDLE;
      storage_mode <= 1'b0;
    end else begin
      st_state <= next_st_state;
      storage_mode <= next_storage_mode;
    end
  end

  alarm_compare alarms (
    .clk(clk), .rst_n(rst_n), .charge_left(charge_left), .mean_time_left(mean_time_left),
    .low_capacity_threshold(low_capacity_threshold), .low_time_threshold(low_time_threshold),
    .battery_mode_word(battery_mode_word), .alarm_capacity(alarm_capacity),
    .alarm_time(alarm_time), .capacity_units_10mw(capacity_units_10mw)
  );

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence write_maint_s;
    cmd_bus.wr && cmd_bus.code == `GG_CMD_MAINT;
  endsequence

  sequence clear_follows_s;
    ##2 (maint_command == 16'h0000 || $past(cmd_bus.wr));
  endsequence

  early_ignore_a: assert property (write_maint_s and !cmd_ready |=> $stable(sealed))
    else $error("command acted on during boot window");
  storage_clear_a: assert property (c_storage and !cmd_bus.rd |-> clear_follows_s)
    else $error("command register not cleared after storage code");
  seal_set_a: assert property (c_seal |=> sealed)
    else $error("seal code did not seal");
  cal_filter_a: assert property (write_maint_s ##0
    (in_cal && !cal_permits(cmd_bus.wdata)) |=> !charge_sync_load && $stable(ee_ctrl))
    else $error("disallowed code acted on during calibration");
  stop_abort_a: assert property (c_stop |=> cal_state == CAL_IDLE ##1 !led_blank)
    else $error("stop code did not abort calibration");
  route_break_a: assert property (ee_ctrl.route && host_addr_valid &&
    host_addr_byte == `GG_BATT_ADDR_WR && !c_prog |=> !ee_ctrl.route)
    else $error("pass-through not broken by battery address");
  revision_a: assert property (c_rev |=> maint_command == REVISION)
    else $error("revision not loaded");
  ocv_order_a: assert property ($rose(offset_correction_valid) |-> $past(cal_saved))
    else $error("valid flag set without save");
  ocv_clear_a: assert property ($rose(cal_ctrl.active) |-> !offset_correction_valid)
    else $error("valid flag not cleared at calibration start");
  sealed_cal_a: assert property (sealed && cal_state == CAL_IDLE |=>
    cal_state == CAL_IDLE)
    else $error("calibration started while sealed");
  storage_gate_a: assert property ($rose(storage_mode) |-> !in_cal)
    else $error("storage entered while calibrating");
endmodule

// *** hw/gauge_regs.svh ***
// Register offsets, command codes, reset values and timing counts of the maintenance block.
`ifndef GAUGE_REGS_SVH
`define GAUGE_REGS_SVH

`define GG_CMD_MAINT 8'h00
`define GG_CMD_LOW_CAP 8'h01
`define GG_CMD_LOW_TIME 8'h02

`define GG_CODE_STORAGE 16'h0618
`define GG_CODE_SEAL 16'h062B
`define GG_CODE_SYNC 16'h064D
`define GG_CODE_CAL 16'h0653
`define GG_CODE_CAL_ALT 16'h067E
`define GG_CODE_CAL_STOP 16'h0660
`define GG_CODE_PROGRAM 16'h0606
`define GG_CODE_REVISION 16'h07E6

`define GG_BATT_ADDR_WR 8'h16
`define GG_CAP_MODE_BIT 15

`define GG_CMD_RESET 16'h0000
`define GG_THRESH_RESET 16'h0000
`define GG_PCT_DIVISOR 24'h000064

`define GG_CLK_HZ 200000000
`define GG_TICK_MS 1
`define GG_TICK_CYCLES ((`GG_CLK_HZ / 1000) * `GG_TICK_MS)

`define GG_TIMER_W 22
`define GG_RESET_IGNORE_MS 1000
`define GG_STORAGE_DELAY_MS 6000
`define GG_CAL_START_MS 100
`define GG_CAL_CAP_MS 3600000
`define GG_POST_CAL_MS 20000

`endif

// *** hw/gauge_pkg.sv ***
// Types shared by the maintenance command block.
package gauge_pkg;

  typedef enum logic [1:0] {CAL_IDLE, CAL_WAIT, CAL_RUN, CAL_SAVE} cal_state_t;

  typedef enum logic [2:0] {ST_IDLE, ST_DELAY, ST_DEFER, ST_FINAL, ST_ENTERED} storage_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] code;
    logic [15:0] wdata;
  } cmd_bus_t;

  typedef struct packed {
    logic active;
    logic sense_disconnect;
    logic save_req;
    logic correction_on;
  } cal_ctrl_t;

  typedef struct packed {
    logic route;
    logic power;
    logic suspend;
  } ee_ctrl_t;

endpackage

// *** hw/tick_timer.sv ***
// Countdown timer that counts millisecond enable pulses and flags expiry for one cycle.
`timescale 1ns/1ps
`include "gauge_regs.svh"
module tick_timer #(
  parameter int W = `GG_TIMER_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic stop,
  output logic running,
  output logic expired
);
  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic next_running;
  logic next_expired;

  generate
    if (W < 2) begin : g_chk
      $error("tick_timer width too small");
    end
  endgenerate

  always_comb begin
    next_count = count;
    next_running = running;
    next_expired = 1'b0;
    if (load) begin
      next_count = load_val;
      next_running = 1'b1;
    end else if (stop) begin
      next_running = 1'b0;
    end else if (running && tick) begin
      if (count <= {{(W-1){1'b0}}, 1'b1}) begin
        next_running = 1'b0;
        next_expired = 1'b1;
      end
      next_count = count - {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      running <= 1'b0;
      expired <= 1'b0;
    end else begin
      count <= next_count;
      running <= next_running;
      expired <= next_expired;
    end
  end
endmodule

// *** hw/alarm_compare.sv ***
// Low-capacity and low-time alarm comparators feeding the alarm broadcast word.
`timescale 1ns/1ps
`include "gauge_regs.svh"
module alarm_compare
  import gauge_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] charge_left,
  input wire logic [15:0] mean_time_left,
  input wire logic [15:0] low_capacity_threshold,
  input wire logic [15:0] low_time_threshold,
  input wire logic [15:0] battery_mode_word,
  output logic alarm_capacity,
  output logic alarm_time,
  output logic capacity_units_10mw
);
  logic next_alarm_capacity;
  logic next_alarm_time;
  logic next_units;

  always_comb begin
    // A zero threshold switches the alarm off.
    next_alarm_capacity = (low_capacity_threshold != 16'h0000) &&
                          (charge_left < low_capacity_threshold);
    next_alarm_time = (low_time_threshold != 16'h0000) &&
                      (mean_time_left < low_time_threshold);
    next_units = battery_mode_word[`GG_CAP_MODE_BIT];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_capacity <= 1'b0;
      alarm_time <= 1'b0;
      capacity_units_10mw <= 1'b0;
    end else begin
      alarm_capacity <= next_alarm_capacity;
      alarm_time <= next_alarm_time;
      capacity_units_10mw <= next_units;
    end
  end

  cap_zero_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    (low_capacity_threshold == 16'h0000) |=> !alarm_capacity)
    else $error("capacity alarm raised with zero threshold");

  time_alarm_a: assert property (@(posedge clk) disable iff (!rst_n)
    (low_time_threshold != 16'h0000 && mean_time_left < low_time_threshold) |=> alarm_time)
    else $error("time alarm missing below threshold");
endmodule

// *** verification/cal_partner.sv ***
// Stand-in for the calibration engine and configuration memory beside the command block.
`timescale 1ns/1ps
module cal_partner
  import gauge_pkg::*;
#(
  parameter int FIND = 8000,
  parameter int SAVE = 20
) (
  input wire logic clk,
  input wire logic nrst,
  input wire cal_ctrl_t cal_ctrl,
  output logic ee_load,
  output logic [15:0] ee_cap_threshold,
  output logic [15:0] ee_time_threshold,
  output logic cal_offset_found,
  output logic cal_saved
);
  int cnt;
  int boot;
  assign ee_cap_threshold = 16'h0123;
  assign ee_time_threshold = 16'h0045;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 0;
      boot <= 0;
      ee_load <= 1'b0;
      cal_offset_found <= 1'b0;
      cal_saved <= 1'b0;
    end else begin
      boot <= (boot < 9) ? boot + 1 : boot;
      ee_load <= (boot == 8);
      cal_offset_found <= 1'b0;
      cal_saved <= 1'b0;
      if (!cal_ctrl.active) begin
        cnt <= 0;
      end else if (cal_ctrl.save_req ? cnt == SAVE : cnt == FIND) begin
        cal_offset_found <= !cal_ctrl.save_req;
        cal_saved <= cal_ctrl.save_req;
        cnt <= 0;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule

// *** verification/maint_command_tb.sv ***
// Self-checking bench for the maintenance command block.
`timescale 1ns/1ps
`include "gauge_regs.svh"
module maint_command_tb
  import gauge_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  cmd_bus_t cmd = '0;
  logic hv = 1'b0;
  logic [7:0] hb = 8'h00;
  logic [15:0] fcc = 16'h03E8;
  logic [7:0] pct = 8'h5F;
  logic [15:0] cl = 16'h0000;
  logic [15:0] mt = 16'h0000;
  logic [15:0] bm = 16'h0000;
  logic [15:0] rdata, ecap, etime, cli;
  logic rv, led, sealed, ocv, stor, sl, ac, at, cu, eel, found, saved;
  cal_ctrl_t cal;
  ee_ctrl_t ee;
  int n_mismatch = 0;
  int total_checks = 0;
  int n_sync = 0;
  int n;

  always #2.5 clk = ~clk;
  always @(posedge clk) if (sl === 1'b1) n_sync++;

  maint_command #(.TICK_CYCLES(1), .REVISION(16'h5A3C)) i_maint_command ( // Arbitrary revision.
    .clk(clk), .nrst(nrst), .cmd_bus(cmd), .reg_rdata(rdata), .reg_rvalid(rv),
    .host_addr_valid(hv), .host_addr_byte(hb), .ee_load(eel), .ee_cap_threshold(ecap),
    .ee_time_threshold(etime), .cal_offset_found(found), .cal_saved(saved),
    .full_charge_capacity_value(fcc), .sync_percent(pct), .charge_left(cl),
    .mean_time_left(mt), .battery_mode_word(bm), .cal_ctrl(cal), .ee_ctrl(ee),
    .led_blank(led), .sealed(sealed), .offset_correction_valid(ocv), .storage_mode(stor),
    .charge_sync_load(sl), .charge_left_internal(cli), .alarm_capacity(ac),
    .alarm_time(at), .capacity_units_10mw(cu));

  cal_partner i_cal_partner (.clk(clk), .nrst(nrst), .cal_ctrl(cal), .ee_load(eel),
    .ee_cap_threshold(ecap), .ee_time_threshold(etime), .cal_offset_found(found),
    .cal_saved(saved));

  ////////////////////////////////////////////////////////////////////////////////
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task chkb(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %b seen %b", nm, e, g);
    end
  endtask

  task wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk);
    cmd.wr <= 1'b1;
    cmd.code <= c;
    cmd.wdata <= d;
    @(posedge clk);
    cmd.wr <= 1'b0;
  endtask

  task rchk(input string nm, input logic [7:0] c, input logic [15:0] e);
    int i;
    @(posedge clk);
    cmd.rd <= 1'b1;
    cmd.code <= c;
    @(posedge clk);
    cmd.rd <= 1'b0;
    i = 0;
    #1;
    while (rv !== 1'b1 && i < 4) begin
      @(posedge clk);
      #1;
      i++;
    end
    chkb("read valid", 1'b1, rv);
    chk(nm, e, rdata);
    if (rv !== 1'b1) wrap_up();
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return cal.active;
      1: return !cal.active;
      2: return ocv;
      3: return stor;
      4: return sl;
      5: return ee.route;
      default: return !ee.route;
    endcase
  endfunction

  task wt(input string nm, input int s, input int lim);
    int i;
    i = 0;
    // Let the edge that launched a one-cycle pulse settle before the first look.
    #1;
    while (sig(s) !== 1'b1 && i < lim) begin
      @(posedge clk);
      #1;
      i++;
    end
    chkb(nm, 1'b1, sig(s));
    if (sig(s) !== 1'b1) wrap_up();
  endtask

  task addr(input logic [7:0] b);
    @(posedge clk);
    hv <= 1'b1;
    hb <= b;
    @(posedge clk);
    hv <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end

  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (20) @(posedge clk);
    rchk("cap threshold", `GG_CMD_LOW_CAP, 16'h0123);
    rchk("time threshold", `GG_CMD_LOW_TIME, 16'h0045);
    rchk("unmapped", 8'h7F, 16'h0000);
    wr(`GG_CMD_MAINT, `GG_CODE_SEAL);
    repeat (4) @(posedge clk);
    chkb("seal in boot", 1'b0, sealed);
    rchk("boot code kept", `GG_CMD_MAINT, `GG_CODE_SEAL);
    repeat (1100) @(posedge clk);
    wr(`GG_CMD_MAINT, `GG_CODE_REVISION);
    rchk("revision", `GG_CMD_MAINT, 16'h5A3C);
    wr(`GG_CMD_MAINT, `GG_CODE_PROGRAM);
    wt("route on", 5, 8);
    chkb("ee power", 1'b1, ee.power);
    chkb("monitor suspend", 1'b1, ee.suspend);
    addr(8'h17);
    repeat (12) @(posedge clk);
    chkb("route kept", 1'b1, ee.route);
    addr(`GG_BATT_ADDR_WR);
    wt("route off", 6, 4);
    wr(`GG_CMD_MAINT, `GG_CODE_SYNC);
    wt("sync pulse", 4, 8);
    chk("sync value", 16'h03B6, cli);
    rchk("sync cleared", `GG_CMD_MAINT, 16'h0000);
    cl <= 16'h0064;
    mt <= 16'h0005;
    bm <= 16'h8000;
    wr(`GG_CMD_LOW_CAP, 16'h00C8);
    wr(`GG_CMD_LOW_TIME, 16'h000A);
    repeat (3) @(posedge clk);
    chkb("cap alarm", 1'b1, ac);
    chkb("time alarm", 1'b1, at);
    chkb("units", 1'b1, cu);
    rchk("cap thr rw", `GG_CMD_LOW_CAP, 16'h00C8);
    wr(`GG_CMD_LOW_CAP, 16'h0000);
    wr(`GG_CMD_LOW_TIME, 16'h0000);
    repeat (3) @(posedge clk);
    chkb("cap alarm off", 1'b0, ac);
    chkb("time alarm off", 1'b0, at);
    wr(`GG_CMD_MAINT, `GG_CODE_CAL_ALT);
    wt("alt cal start", 0, 3200);
    chkb("sense kept", 1'b0, cal.sense_disconnect);
    chkb("led blank", 1'b1, led);
    wr(`GG_CMD_MAINT, `GG_CODE_CAL_STOP);
    wt("cal abort", 1, 8);
    chkb("correction off", 1'b0, cal.correction_on);
    chkb("valid after abort", 1'b0, ocv);
    wr(`GG_CMD_MAINT, `GG_CODE_STORAGE);
    rchk("storage cleared", `GG_CMD_MAINT, 16'h0000);
    repeat (1000) @(posedge clk);
    wr(`GG_CMD_MAINT, `GG_CODE_CAL);
    wt("cal start", 0, 3200);
    chkb("sense off", 1'b1, cal.sense_disconnect);
    chkb("valid cleared", 1'b0, ocv);
    n = n_sync;
    wr(`GG_CMD_MAINT, `GG_CODE_SYNC);
    repeat (8) @(posedge clk);
    chk("sync ignored", n[15:0], n_sync[15:0]);
    wt("cal saved", 2, 9000);
    chkb("correction on", 1'b1, cal.correction_on);
    chkb("storage deferred", 1'b0, stor);
    repeat (19900) @(posedge clk);
    chkb("storage early", 1'b0, stor);
    wt("storage entered", 3, 300);
    wr(`GG_CMD_MAINT, `GG_CODE_SEAL);
    repeat (3) @(posedge clk);
    chkb("sealed", 1'b1, sealed);
    rchk("seal cleared", `GG_CMD_MAINT, 16'h0000);
    wr(`GG_CMD_MAINT, `GG_CODE_CAL);
    repeat (200) @(posedge clk);
    chkb("sealed cal refused", 1'b0, cal.active);
    wrap_up();
  end
endmodule
